/* File: hw/scr_pkg.sv */
// scr_pkg: register map, field positions, modes and shared helpers
// for one serial channel; every design file but scr_sync imports it whole.
package scr_pkg;

  localparam int SCR_AW = 4;
  localparam int SCR_DW = 16;
  localparam int SCR_CW = 9;

  // register indices on the plain register port
  localparam logic [3:0] SCR_REG_MODE  = 4'h0;
  localparam logic [3:0] SCR_REG_CTRL0 = 4'h1;
  localparam logic [3:0] SCR_REG_CTRL1 = 4'h2;
  localparam logic [3:0] SCR_REG_TXBUF = 4'h3;
  localparam logic [3:0] SCR_REG_RXBUF = 4'h4;
  localparam logic [3:0] SCR_REG_COND  = 4'h5;
  localparam logic [3:0] SCR_REG_STAT  = 4'h6;
  localparam logic [3:0] SCR_REG_MASK  = 4'h7;
  localparam logic [3:0] SCR_REG_DIV   = 4'h8;

  // serial mode field encodings
  localparam logic [2:0] SCR_MODE_OFF  = 3'h0;
  localparam logic [2:0] SCR_MODE_SYNC = 3'h1;
  localparam logic [2:0] SCR_MODE_A7   = 3'h4;
  localparam logic [2:0] SCR_MODE_A8   = 3'h5;
  localparam logic [2:0] SCR_MODE_A9   = 3'h6;

  // field positions
  localparam int SCR_MODE_EXTCLK = 3;
  localparam int SCR_MODE_OUTEN  = 4;
  localparam int SCR_C0_POL      = 0;
  localparam int SCR_C1_TXEN     = 0;
  localparam int SCR_C1_RXEN     = 1;
  localparam int SCR_C1_TXEMPTY  = 2;
  localparam int SCR_C1_RXDONE   = 3;
  localparam int SCR_RXB_OVR     = 15;
  localparam int SCR_ST_TXE      = 0;
  localparam int SCR_ST_RXC      = 1;
  localparam int SCR_ST_OVR      = 2;

  // reset values and counts
  localparam logic [7:0] SCR_DIV_RST    = 8'h04;
  localparam logic [3:0] SCR_SYNC_BITS  = 4'h8;
  localparam logic [3:0] SCR_OVR_IDX    = 4'h6;
  localparam logic [3:0] SCR_FRAME_XTRA = 4'h2;

  typedef enum logic [1:0] {
    SCR_RX_IDLE, SCR_RX_START, SCR_RX_DATA, SCR_RX_STOP
  } scr_rx_state_t;

  // character length for a mode; clocked mode is always 8 bits
  function automatic logic [3:0] scr_char_len(input logic [2:0] m);
    case (m)
      SCR_MODE_A7: scr_char_len = 4'h7;
      SCR_MODE_A9: scr_char_len = 4'h9;
      default:     scr_char_len = 4'h8;
    endcase
  endfunction

endpackage

/* File: hw/scr_sync.sv */
// scr_sync: two-flop synchroniser for pins from outside the clock domain.
// assumes each bit is an independent level; no bus coherency is given.
`timescale 1ns/100ps
module scr_sync #(
  parameter int W = 2
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta;

  // first stage feeds only the second stage
  always_ff @(posedge clk) begin
    if (rst) begin
      meta <= '1;
      q    <= '1;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end

endmodule

/* File: hw/scr_div.sv */
// scr_div: bit-rate down counter, one tick every period+1 cycles.
// assumes run is held for the whole transfer; dropping it reloads first.
`timescale 1ns/100ps
module scr_div
  import scr_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       run,
  input  wire logic [7:0] first,
  input  wire logic [7:0] period,
  output logic            tick
);

  logic [7:0] cnt;

  // first interval may differ so a receiver can aim at mid-bit
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt <= 8'h00;
    end else if (!run) begin
      cnt <= first;
    end else if (cnt == 8'h00) begin
      cnt <= period;
    end else begin
      cnt <= cnt - 8'h01;
    end
  end

  assign tick = run && (cnt == 8'h00);

endmodule

/* File: hw/scr_channel.sv */
// scr_channel: one serial channel, clocked synchronous and character
// modes, with overrun detection and mode-field recovery.
// assumes a plain register port on clk and pins from another domain.
//
// Strobed register access and the placing of the registers were decided locally.
`timescale 1ns/100ps

// Behaviour
// - polarity 0: shift on fall, sample rise
// - transmit side alone produces the serial clock
// - dummy data leaves output pin while receiving
// - overrun when done flag set at seventh bit
// - receive buffer undefined after an overrun
// - synchronous recovery: disable, mode 000b, 001b, enable
// - character recovery: disable, 000b, then 100b..110b
module scr_channel
  import scr_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic [SCR_AW-1:0] reg_addr,
  input  wire logic [SCR_DW-1:0] reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [SCR_DW-1:0] reg_rdata,
  input  wire logic              ext_clk,
  input  wire logic              rxd_pin,
  output logic                   serial_out_pin,
  output logic                   serial_out_oe_n,
  output logic                   clk_out_pin,
  output logic                   clk_out_oe_n,
  output logic                   irq
);

  // software-visible state
  logic [2:0]        serial_mode_field;
  logic              ext_clk_sel;
  logic              out_pin_en;
  logic              clock_polarity_select;
  logic              tx_enable_bit;
  logic              rx_enable_bit;
  logic              tx_buf_full;
  logic              rx_complete_flag;
  logic              overrun_flag;
  logic [SCR_CW-1:0] tx_buffer_register;
  logic [SCR_CW-1:0] rx_buffer_register;
  logic              condition_output_select;
  logic              start_request_bit;
  logic              restart_request_bit;
  logic              stop_request_bit;
  logic [2:0]        irq_status;
  logic [2:0]        irq_mask;
  logic [7:0]        bit_div;

  // shift state
  logic              tx_active;
  logic [3:0]        tx_cnt;
  logic [10:0]       tx_shift;
  logic              clk_out;
  scr_rx_state_t     rx_state;
  logic [3:0]        rx_cnt;
  logic [SCR_CW-1:0] rx_shift;
  logic [SCR_CW-1:0] rx_shift_next;
  logic              char_ovr;

  // pin sampling
  logic [1:0]        pin_q;
  logic              ext_prev;
  logic              rxd_prev;
  logic              tick_tx;
  logic              tick_rx;

  // decoded controls and events
  logic        sync_mode;
  logic        uart_mode;
  logic        idle_lvl;
  logic        chan_reset;
  logic        mode_write;
  logic        tx_start;
  logic        ext_shift;
  logic        ext_sample;
  logic        shift_ev;
  logic        sample_ev;
  logic [3:0]  char_len;
  logic        rx_bit_ev;
  logic [3:0]  rx_bit_idx;
  logic        rx_done_ev;
  logic        ovr_ev;
  logic        rxbuf_read;
  logic        stat_read;
  logic [SCR_DW-1:0] rd_value;

  // align a received character that was shifted in from the top
  function automatic logic [SCR_CW-1:0] scr_align(
    input logic [SCR_CW-1:0] d,
    input logic [3:0]        n
  );
    case (n)
      4'h7:    scr_align = {2'h0, d[8:2]};
      4'h8:    scr_align = {1'h0, d[8:1]};
      default: scr_align = d;
    endcase
  endfunction

  // unused bits above the character act as stop level
  function automatic logic [10:0] scr_frame(
    input logic [SCR_CW-1:0] d,
    input logic [3:0]        n
  );
    case (n)
      4'h7:    scr_frame = {3'h7, d[6:0], 1'h0};
      4'h8:    scr_frame = {2'h3, d[7:0], 1'h0};
      default: scr_frame = {1'h1, d, 1'h0};
    endcase
  endfunction

  scr_sync #(
    .W (2)
  ) u_sync (
    .clk (clk),
    .rst (rst),
    .d   ({ext_clk, rxd_pin}),
    .q   (pin_q)
  );

  scr_div u_tx_div (
    .clk    (clk),
    .rst    (rst),
    .run    (tx_active),
    .first  (bit_div),
    .period (bit_div),
    .tick   (tick_tx)
  );

  scr_div u_rx_div (
    .clk    (clk),
    .rst    (rst),
    .run    (rx_state != SCR_RX_IDLE),
    .first  ({1'h0, bit_div[7:1]}),
    .period (bit_div),
    .tick   (tick_rx)
  );

  // mode decode; any mode write reinitialises the shifters
  assign mode_write = reg_wr && (reg_addr == SCR_REG_MODE);
  assign sync_mode  = serial_mode_field == SCR_MODE_SYNC;
  assign uart_mode  = (serial_mode_field == SCR_MODE_A7) ||
                      (serial_mode_field == SCR_MODE_A8) ||
                      (serial_mode_field == SCR_MODE_A9);
  assign chan_reset = mode_write ||
                      (serial_mode_field == SCR_MODE_OFF);
  assign char_len   = sync_mode ? SCR_SYNC_BITS
                                : scr_char_len(serial_mode_field);
  assign rxbuf_read = reg_rd && (reg_addr == SCR_REG_RXBUF);
  assign stat_read  = reg_rd && (reg_addr == SCR_REG_STAT);

  // idle clock level is high for polarity 0, low for polarity 1
  assign idle_lvl   = ~clock_polarity_select;
  assign ext_shift  = (pin_q[1] != ext_prev) && (pin_q[1] != idle_lvl);
  assign ext_sample = (pin_q[1] != ext_prev) && (pin_q[1] == idle_lvl);

  // edges count only while the transmit side runs a loaded character
  always_comb begin
    shift_ev  = 1'b0;
    sample_ev = 1'b0;
    if (tx_active && sync_mode) begin
      if (ext_clk_sel) begin
        shift_ev  = ext_shift;
        sample_ev = ext_sample;
      end else begin
        shift_ev  = tick_tx && (clk_out == idle_lvl);
        sample_ev = tick_tx && (clk_out != idle_lvl);
      end
    end
  end

  // receive needs no part in starting a transfer
  assign tx_start = !tx_active && tx_enable_bit && tx_buf_full &&
                    (sync_mode || uart_mode) && !chan_reset;

  // edge history of the synchronised pins
  always_ff @(posedge clk) begin
    if (rst) begin
      ext_prev <= 1'b1;
      rxd_prev <= 1'b1;
    end else begin
      ext_prev <= pin_q[1];
      rxd_prev <= pin_q[0];
    end
  end

  // transmit shifter; in clocked mode it also shifts dummy data on receive
  always_ff @(posedge clk) begin
    if (rst || chan_reset) begin
      tx_active      <= 1'b0;
      tx_cnt         <= 4'h0;
      tx_shift       <= '1;
      serial_out_pin <= 1'b1;
    end else if (tx_start) begin
      tx_active <= 1'b1;
      tx_cnt    <= 4'h0;
      tx_shift  <= sync_mode ? {2'h3, tx_buffer_register}
                             : scr_frame(tx_buffer_register, char_len);
    end else if (uart_mode && tick_tx) begin
      serial_out_pin <= tx_shift[0];
      tx_shift       <= {1'b1, tx_shift[10:1]};
      tx_cnt         <= tx_cnt + 4'h1;
      if (tx_cnt == char_len + SCR_FRAME_XTRA - 4'h1) begin
        tx_active <= 1'b0;
      end
    end else if (shift_ev) begin
      serial_out_pin <= tx_shift[0];
      tx_shift       <= {1'b1, tx_shift[10:1]};
    end else if (sample_ev) begin
      tx_cnt <= tx_cnt + 4'h1;
      if (tx_cnt == SCR_SYNC_BITS - 4'h1) begin
        tx_active <= 1'b0;
      end
    end
  end

  // own clock toggles only during a transfer and rests at idle level
  always_ff @(posedge clk) begin
    if (rst) begin
      clk_out <= 1'b1;
    end else if (!tx_active || ext_clk_sel || !sync_mode) begin
      clk_out <= idle_lvl;
    end else if (tick_tx) begin
      clk_out <= ~clk_out;
    end
  end

  // driven pins; enables are low while the pin is driven
  assign clk_out_pin     = clk_out;
  assign clk_out_oe_n    = ~(sync_mode && !ext_clk_sel);
  assign serial_out_oe_n = ~out_pin_en;

  // character receiver: start check at mid-bit, then one sample per bit
  always_ff @(posedge clk) begin
    if (rst || chan_reset) begin
      rx_state <= SCR_RX_IDLE;
      rx_cnt   <= 4'h0;
    end else begin
      case (rx_state)
        SCR_RX_IDLE: begin
          if (uart_mode && rx_enable_bit && rxd_prev && !pin_q[0]) begin
            rx_state <= SCR_RX_START;
          end
        end
        SCR_RX_START: begin
          if (tick_rx) begin
            rx_cnt   <= 4'h0;
            rx_state <= pin_q[0] ? SCR_RX_IDLE : SCR_RX_DATA;
          end
        end
        SCR_RX_DATA: begin
          if (tick_rx) begin
            rx_cnt <= rx_cnt + 4'h1;
            if (rx_cnt == char_len - 4'h1) begin
              rx_state <= SCR_RX_STOP;
            end
          end
        end
        SCR_RX_STOP: begin
          if (tick_rx) begin
            rx_state <= SCR_RX_IDLE;
          end
        end
        default: rx_state <= SCR_RX_IDLE;
      endcase
    end
  end

  // one receive bit path for both modes
  assign rx_bit_ev  = sync_mode ? (sample_ev && rx_enable_bit)
                                : (rx_state == SCR_RX_DATA && tick_rx);
  assign rx_bit_idx = sync_mode ? tx_cnt : rx_cnt;
  assign rx_done_ev = sync_mode ? (sample_ev && rx_enable_bit &&
                                   tx_cnt == SCR_SYNC_BITS - 4'h1)
                                : (rx_state == SCR_RX_STOP && tick_rx);
  assign ovr_ev     = rx_bit_ev && (rx_bit_idx == SCR_OVR_IDX) &&
                      rx_complete_flag;

  // value after this cycle's bit; in clocked mode the last bit and the
  // buffer load share one edge, so the buffer must see this value
  assign rx_shift_next = rx_bit_ev ? {pin_q[0], rx_shift[SCR_CW-1:1]}
                                   : rx_shift;

  // receive shift register fills from the top
  always_ff @(posedge clk) begin
    if (rst || chan_reset) begin
      rx_shift <= '0;
    end else if (rx_bit_ev) begin
      rx_shift <= rx_shift_next;
    end
  end

  // buffer still loads after an overrun; its content is not trusted then
  always_ff @(posedge clk) begin
    if (rst || chan_reset) begin
      rx_buffer_register <= '0;
      rx_complete_flag   <= 1'b0;
      char_ovr           <= 1'b0;
    end else begin
      if (ovr_ev) begin
        char_ovr <= 1'b1;
      end
      if (rx_done_ev) begin
        rx_buffer_register <= scr_align(rx_shift_next, char_len);
        rx_complete_flag   <= 1'b1;
        char_ovr           <= 1'b0;
      end else if (rxbuf_read) begin
        rx_complete_flag <= 1'b0;
      end
    end
  end

  // overrun stays until receive is disabled or the mode is rewritten
  always_ff @(posedge clk) begin
    if (rst || chan_reset) begin
      overrun_flag <= 1'b0;
    end else if (ovr_ev) begin
      overrun_flag <= 1'b1;
    end else if (!rx_enable_bit) begin
      overrun_flag <= 1'b0;
    end
  end

  // sticky events; a new event wins over the clearing read
  always_ff @(posedge clk) begin
    if (rst) begin
      irq_status <= 3'h0;
    end else begin
      irq_status <= (stat_read ? 3'h0 : irq_status) |
                    {ovr_ev,
                     rx_done_ev && !char_ovr && !ovr_ev,
                     tx_start};
    end
  end

  assign irq = |(irq_status & irq_mask);

  // transmit buffer: a write sets full even in the cycle it is taken
  always_ff @(posedge clk) begin
    if (rst) begin
      tx_buffer_register <= '0;
      tx_buf_full        <= 1'b0;
    end else if (reg_wr && reg_addr == SCR_REG_TXBUF) begin
      tx_buffer_register <= reg_wdata[SCR_CW-1:0];
      tx_buf_full        <= 1'b1;
    end else if (tx_start || chan_reset) begin
      tx_buf_full <= 1'b0;
    end
  end

  // control registers written by software
  always_ff @(posedge clk) begin
    if (rst) begin
      serial_mode_field       <= SCR_MODE_OFF;
      ext_clk_sel             <= 1'b0;
      out_pin_en              <= 1'b0;
      clock_polarity_select   <= 1'b0;
      tx_enable_bit           <= 1'b0;
      rx_enable_bit           <= 1'b0;
      condition_output_select <= 1'b0;
      start_request_bit       <= 1'b0;
      restart_request_bit     <= 1'b0;
      stop_request_bit        <= 1'b0;
      irq_mask                <= 3'h0;
      bit_div                 <= SCR_DIV_RST;
    end else if (reg_wr) begin
      case (reg_addr)
        SCR_REG_MODE: begin
          serial_mode_field <= reg_wdata[2:0];
          ext_clk_sel       <= reg_wdata[SCR_MODE_EXTCLK];
          out_pin_en        <= reg_wdata[SCR_MODE_OUTEN];
        end
        SCR_REG_CTRL0: clock_polarity_select <= reg_wdata[SCR_C0_POL];
        SCR_REG_CTRL1: begin
          tx_enable_bit <= reg_wdata[SCR_C1_TXEN];
          rx_enable_bit <= reg_wdata[SCR_C1_RXEN];
        end
        SCR_REG_COND: begin
          condition_output_select <= reg_wdata[0];
          start_request_bit       <= reg_wdata[1];
          restart_request_bit     <= reg_wdata[2];
          stop_request_bit        <= reg_wdata[3];
        end
        SCR_REG_MASK: irq_mask <= reg_wdata[2:0];
        SCR_REG_DIV:  bit_div  <= reg_wdata[7:0];
        default: ;
      endcase
    end
  end

  // read mux; unmapped addresses read zero
  always_comb begin
    rd_value = '0;
    case (reg_addr)
      SCR_REG_MODE: begin
        rd_value[2:0]            = serial_mode_field;
        rd_value[SCR_MODE_EXTCLK] = ext_clk_sel;
        rd_value[SCR_MODE_OUTEN]  = out_pin_en;
      end
      SCR_REG_CTRL0: rd_value[SCR_C0_POL] = clock_polarity_select;
      SCR_REG_CTRL1: begin
        rd_value[SCR_C1_TXEN]    = tx_enable_bit;
        rd_value[SCR_C1_RXEN]    = rx_enable_bit;
        rd_value[SCR_C1_TXEMPTY] = ~tx_buf_full;
        rd_value[SCR_C1_RXDONE]  = rx_complete_flag;
      end
      SCR_REG_TXBUF: rd_value[SCR_CW-1:0] = tx_buffer_register;
      SCR_REG_RXBUF: begin
        rd_value[SCR_CW-1:0]  = rx_buffer_register;
        rd_value[SCR_RXB_OVR] = overrun_flag;
      end
      SCR_REG_COND: rd_value[3:0] = {stop_request_bit, restart_request_bit,
                                     start_request_bit,
                                     condition_output_select};
      SCR_REG_STAT: rd_value[2:0] = irq_status;
      SCR_REG_MASK: rd_value[2:0] = irq_mask;
      SCR_REG_DIV:  rd_value[7:0] = bit_div;
      default: rd_value = '0;
    endcase
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge clk) begin
    if (rst) begin
      reg_rdata <= '0;
    end else begin
      reg_rdata <= reg_rd ? rd_value : '0;
    end
  end

endmodule

/* File: sim/scr_channel_sva.sv */
// scr_channel_sva: port-level checker for one serial channel.
// assumes it is bound to scr_channel and sees only its ports.
`timescale 1ns/100ps
module scr_channel_sva
  import scr_pkg::*;
(
  input wire logic              clk,
  input wire logic              rst,
  input wire logic [SCR_AW-1:0] reg_addr,
  input wire logic [SCR_DW-1:0] reg_wdata,
  input wire logic              reg_wr,
  input wire logic              reg_rd,
  input wire logic [SCR_DW-1:0] reg_rdata,
  input wire logic              ext_clk,
  input wire logic              rxd_pin,
  input wire logic              serial_out_pin,
  input wire logic              serial_out_oe_n,
  input wire logic              clk_out_pin,
  input wire logic              clk_out_oe_n,
  input wire logic              irq
);
  logic [4:0] mode_q;
  logic [2:0] mask_q;
  logic       wr01;
  logic       int_clk;

  // polarity or mode writes may legally move the clock pin once
  assign wr01    = reg_wr && reg_addr <= SCR_REG_CTRL0;
  assign int_clk = mode_q[2:0] == SCR_MODE_SYNC && !mode_q[SCR_MODE_EXTCLK];

  // shadow of the mode register, taken from the write strobe
  always_ff @(posedge clk) begin
    if (rst) begin
      mode_q <= 5'h00;
    end else if (reg_wr && reg_addr == SCR_REG_MODE) begin
      mode_q <= reg_wdata[4:0];
    end
  end

  // shadow of the interrupt mask
  always_ff @(posedge clk) begin
    if (rst) begin
      mask_q <= 3'h0;
    end else if (reg_wr && reg_addr == SCR_REG_MASK) begin
      mask_q <= reg_wdata[2:0];
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  rdata_zero_a: assert property (!reg_rd |=> reg_rdata == '0)
    else $error("read data not zero outside a read answer");
  unmapped_rd_a: assert property (reg_rd && reg_addr > SCR_REG_DIV
    |=> reg_rdata == '0) else $error("unmapped read returned data");
  irq_mask_a: assert property (mask_q == 3'h0 |-> !irq)
    else $error("interrupt raised with all sources masked");
  out_oe_a: assert property (
    serial_out_oe_n == !mode_q[SCR_MODE_OUTEN])
    else $error("serial output enable does not follow mode");
  clk_oe_a: assert property (clk_out_oe_n == !int_clk)
    else $error("clock output enable outside internal clocked mode");
  off_idle_a: assert property (mode_q[2:0] == SCR_MODE_OFF &&
    $past(mode_q[2:0]) == SCR_MODE_OFF |-> serial_out_pin)
    else $error("serial output not idle while channel off");
  clk_quiet_a: assert property ((!int_clk && !wr01)[*4]
    |-> $stable(clk_out_pin)) else $error("clock pin moved without owner");
  off_flags_a: assert property (
    reg_rd && reg_addr == SCR_REG_CTRL1 &&
    mode_q[2:0] == SCR_MODE_OFF |=> reg_rdata[3:2] == 2'b01)
    else $error("flags not reset while channel off");
  off_rxbuf_a: assert property (
    reg_rd && reg_addr == SCR_REG_RXBUF &&
    mode_q[2:0] == SCR_MODE_OFF |=> reg_rdata == '0)
    else $error("receive buffer not cleared while channel off");

  cover property (reg_rd && reg_addr == SCR_REG_STAT ##1 reg_rdata[2]);
  cover property ($rose(irq));
  cover property (reg_rd && reg_addr == SCR_REG_RXBUF ##1 reg_rdata != '0);
endmodule

bind scr_channel scr_channel_sva u_sva (
  .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .ext_clk(ext_clk), .rxd_pin(rxd_pin), .serial_out_pin(serial_out_pin),
  .serial_out_oe_n(serial_out_oe_n), .clk_out_pin(clk_out_pin),
  .clk_out_oe_n(clk_out_oe_n), .irq(irq)
);

/* File: sim/scr_peer.sv */
// scr_peer: far-end serial device; drives the link clock inside frames
// only and the receive line. assumes one caller at a time.
`timescale 1ns/100ps
module scr_peer #(
  parameter int CLK_HALF = 40,
  parameter int BIT_NS   = 50
) (
  output logic      ext_clk,
  output logic      rxd_pin,
  input  wire logic serial_out_pin
);
  logic idle = 1'b1;

  initial begin
    ext_clk = 1'b1;
    rxd_pin = 1'b1;
  end

  // park the clock at idle before the channel gets armed
  task automatic set_idle(input logic lvl);
    idle    = lvl;
    ext_clk = lvl;
    rxd_pin = 1'b1;
  endtask

  // one clocked byte, LSB first; the output is read late in each bit
  // because the channel resynchronises the clock first
  task automatic xfer(input logic [7:0] tx, output logic [7:0] seen);
    #3;
    for (int i = 0; i < 8; i++) begin
      ext_clk = ~idle;
      rxd_pin = tx[i];
      #(CLK_HALF);
      ext_clk = idle;
      #(CLK_HALF - 1);
      seen[i] = serial_out_pin;
      #1;
    end
    rxd_pin = ~rxd_pin; // released line must not hold the last bit
  endtask

  // one character frame: start low, data LSB first, stop high
  task automatic send_char(input logic [8:0] v, input int n);
    rxd_pin = 1'b0;
    #(BIT_NS);
    for (int i = 0; i < n; i++) begin
      rxd_pin = v[i];
      #(BIT_NS);
    end
    rxd_pin = 1'b1;
    #(BIT_NS);
  endtask
endmodule

/* File: sim/scr_channel_tb.sv */
// scr_channel_tb: self-checking bench for the serial channel.
// assumes scr_peer on the pins and the checker bound to the channel.
`timescale 1ns/100ps
module scr_channel_tb
  import scr_pkg::*;
;
  logic              clk = 1'b0;
  logic              rst = 1'b1;
  logic [SCR_AW-1:0] reg_addr = '0;
  logic [SCR_DW-1:0] reg_wdata = '0;
  logic              reg_wr = 1'b0;
  logic              reg_rd = 1'b0;
  logic [SCR_DW-1:0] reg_rdata;
  logic              ext_clk, rxd_pin, serial_out_pin, serial_out_oe_n;
  logic              clk_out_pin, clk_out_oe_n, irq;
  logic [8:0]        d, t, got;
  logic              cprev = 1'b1;
  int                nb = 0;
  logic [7:0]        e, seen;
  int                miscompares = 0;
  int                cmp_count = 0;

  always #5 clk = ~clk;

  scr_channel dut (
    .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .ext_clk(ext_clk), .rxd_pin(rxd_pin), .serial_out_pin(serial_out_pin),
    .serial_out_oe_n(serial_out_oe_n), .clk_out_pin(clk_out_pin),
    .clk_out_oe_n(clk_out_oe_n), .irq(irq));
  scr_peer peer (.ext_clk(ext_clk), .rxd_pin(rxd_pin),
    .serial_out_pin(serial_out_pin));

  task automatic stop_test();
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [15:0] x,
                     input logic [15:0] s);
    cmp_count++;
    if (s !== x) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", n, x, s);
    end
  endtask

  // one access every two cycles so a strobe is never set twice at once
  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rdc(input string n, input logic [3:0] a,
                     input logic [15:0] m, input logic [15:0] x);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
    chk(n, x & m, reg_rdata & m);
  endtask

  task automatic cfg(input logic [4:0] m, input logic p,
                     input logic [1:0] en);
    peer.set_idle(~p);
    wr(SCR_REG_MODE, {11'h000, m});
    wr(SCR_REG_CTRL0, {15'h0000, p});
    wr(SCR_REG_CTRL1, {14'h0000, en});
  endtask

  // overrun character keeps rx complete out of the status word
  function automatic logic [15:0] exp_stat(input logic ovr);
    exp_stat = ovr ? 16'h0005 : 16'h0003;
  endfunction

  function automatic logic [15:0] rx_word(input logic [8:0] v, input int n);
    rx_word = {7'h00, v & 9'((1 << n) - 1)};
  endfunction

  // one character off the output pin, taken near mid-bit
  task automatic get_char(input int n, output logic [8:0] v);
    int c;
    c = 0;
    v = '0;
    while (serial_out_pin && c < 200) begin
      @(posedge clk);
      c++;
    end
    if (c == 200) miscompares++;
    repeat (2) @(posedge clk);
    for (int i = 0; i < n; i++) begin
      repeat (int'(SCR_DIV_RST) + 1) @(posedge clk);
      v[i] = serial_out_pin;
    end
  endtask

  initial begin
    repeat (100000) @(posedge clk);
    miscompares++;
    stop_test();
  end

  initial begin
    void'($urandom(52014));
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rdc("div", SCR_REG_DIV, 16'hFFFF, {8'h00, SCR_DIV_RST});
    rdc("ctrl1", SCR_REG_CTRL1, 16'hFFFF, 16'h0004);
    wr(4'h9, 16'hFFFF);
    rdc("unmapped", 4'h9, 16'hFFFF, 16'h0000);
    // pass 2 leaves its character unread so pass 3 overruns
    for (int k = 0; k < 5; k++) begin
      if (k == 4) begin
        wr(SCR_REG_CTRL1, 16'h0000);
        wr(SCR_REG_MODE, 16'h0000);
        rdc("off_flags", SCR_REG_CTRL1, 16'h000C, 16'h0004);
        rdc("off_rxbuf", SCR_REG_RXBUF, 16'hFFFF, 16'h0000);
      end
      if (k < 2 || k == 4) cfg(5'h19, k == 1, 2'h3);
      d = 9'($urandom_range(255));
      e = 8'($urandom_range(255));
      wr(SCR_REG_TXBUF, {7'h00, d});
      peer.xfer(e, seen);
      repeat (6) @(posedge clk); // synchroniser and sample latency
      chk("peer_rx", {8'h00, d[7:0]}, {8'h00, seen});
      if (k == 0) begin
        wr(SCR_REG_MASK, 16'h0002);
        chk("irq_rx", 16'h0001, {15'h0000, irq});
        wr(SCR_REG_MASK, 16'h0004);
      end
      chk("irq_ovr", {15'h0000, k == 3}, {15'h0000, irq});
      rdc("stat", SCR_REG_STAT, 16'h0007, exp_stat(k == 3));
      chk("irq_clr", 16'h0000, {15'h0000, irq});
      if (k != 2) rdc("rxbuf", SCR_REG_RXBUF, k == 3 ? 16'h8000 : 16'h80FF,
        k == 3 ? 16'h8000 : {8'h00, e});
    end
    // character modes, each entered through the off state
    for (int j = 0; j < 3; j++) begin
      wr(SCR_REG_CTRL1, 16'h0000);
      cfg(5'h00, 1'b0, 2'h0);
      cfg({2'b00, 3'(4 + j)}, 1'b0, 2'h3);
      d = 9'($urandom_range(511));
      t = 9'($urandom_range(511));
      wr(SCR_REG_TXBUF, {7'h00, t});
      fork
        peer.send_char(d, 7 + j);
        get_char(7 + j, got);
      join
      chk("char_tx", rx_word(t, 7 + j), {7'h00, got});
      repeat (6) @(posedge clk);
      rdc("char_rx", SCR_REG_RXBUF, 16'hFFFF, rx_word(d, 7 + j));
    end
    // own clock, transmit only: take the pin on each return to idle
    wr(SCR_REG_CTRL1, 16'h0000);
    cfg(5'h11, 1'b0, 2'h1);
    t = 9'($urandom_range(255));
    wr(SCR_REG_TXBUF, {7'h00, t});
    got = '0;
    repeat (200) begin
      @(posedge clk);
      if (clk_out_pin && !cprev) begin
        got[nb] = serial_out_pin;
        nb++;
      end
      cprev = clk_out_pin;
    end
    chk("int_tx", {7'h00, t}, {7'h00, got});
    chk("int_edges", 16'h0008, 16'(nb));
    // start, restart and stop requests after the select bit is cleared
    for (int b = 1; b < 4; b++) begin
      wr(SCR_REG_COND, 16'h0000);
      repeat (3) @(posedge clk);
      wr(SCR_REG_COND, 16'(1 << b));
      rdc("cond", SCR_REG_COND, 16'h000F, 16'(1 << b));
    end
    stop_test();
  end
endmodule
